// file: dcffm_pkg.sv
// Shared constants for the dual-timing-mode flagged FIFO
package dcffm_pkg;

  // ==========================================================================
  // Sizes
  localparam int DCFFM_DATA_W = 72;
  localparam int DCFFM_ADDR_W = 9;
  localparam int DCFFM_STAGE_DEPTH = 8;

  // ==========================================================================
  // Clock and start-up timing
  localparam int DCFFM_CLK_PERIOD_NS = 50;
  localparam logic [1:0] DCFFM_BOOT_RST = 2'h0;
  localparam logic [1:0] DCFFM_BOOT_CAPTURE = 2'h2;
  localparam logic [1:0] DCFFM_BOOT_DONE = 2'h3;

  // ==========================================================================
  // Flag and mode reset values (flags active low, mode high for fall-through)
  localparam logic DCFFM_EMPTY_RST = 1'b0;
  localparam logic DCFFM_FULL_RST = 1'b1;
  localparam logic DCFFM_INRDY_RST = 1'b0;
  localparam logic DCFFM_AEMPTY_RST = 1'b0;
  localparam logic DCFFM_AFULL_RST = 1'b1;
  localparam logic DCFFM_HALF_RST = 1'b1;
  localparam logic DCFFM_MODE_RST = 1'b0;

endpackage

// file: dcffm_stream_if.sv
// Valid/ready word stream between the FIFO core and its staging buffer
`timescale 1ns/10ps
interface dcffm_stream_if #(
  parameter int W = 72
) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: dcffm_stage_fifo.sv
// Small staging FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dcffm_stage_fifo
  import dcffm_pkg::*;
#(
  parameter int W = DCFFM_DATA_W,
  parameter int DEPTH = DCFFM_STAGE_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  dcffm_stream_if.snk push,
  dcffm_stream_if.src pop
);

  // ==========================================================================
  // State
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_C = (AW+1)'(1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dcffm_fifo_state_t;

  dcffm_fifo_state_t q, d;
  logic [W-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  // Honest flags: ready drops only when every slot holds a word
  assign push.ready = (q.cnt != FULL_C);
  assign pop.valid = (q.cnt != '0);
  assign pop.data = mem[q.rp];
  assign do_push = push.valid & push.ready;
  assign do_pop = pop.valid & pop.ready;

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    if (do_push) begin
      d.wp = q.wp + 1'b1;
    end
    if (do_pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      d.cnt = q.cnt + ONE_C;
    end else if (do_pop && !do_push) begin
      d.cnt = q.cnt - ONE_C;
    end
  end

  // Storage has no reset; only words marked valid are ever read
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[q.wp] <= push.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// file: dcffm_top.sv
// FIFO core with standard and fall-through timing modes and status flags
`timescale 1ns/10ps
// Behaviour
// - Select low at reset picks standard mode; set it before reset ends.
// - Select high at reset picks fall-through mode.
// - Fall-through: first word reaches outputs three read edges after arrival.
// - Words are stored only while write enable is low, on clock edges.
// - Standard: empty flag rises after first word is written.
// - Standard: almost-empty rises when count reaches empty offset plus one.
// - Standard: half-full falls when count exceeds half the depth.
// - Standard: almost-full falls when count reaches depth minus full offset.
// - Standard: full flag falls after depth writes; writes then blocked.
// - Standard: read raises full; almost-empty falls at offset words left.
// - Standard: empty flag falls when last word read; reads blocked.
// - Read enable is ignored while empty; pointer and outputs hold.
// - Standard: empty and full flags pass two register stages.
// - Fall-through: output-ready falls after first word is written.
// - Fall-through: almost-empty rises at empty offset plus two words.
// - Fall-through: half-full falls at half the depth plus two words.
// - Fall-through: almost-full falls at depth plus one minus offset.
// - Fall-through: input-ready rises after depth plus one writes; blocks.
// - Fall-through: read lowers input-ready; almost-empty at offset plus one.
// - Fall-through: output-ready rises when last word read; reads blocked.
// - Fall-through: output-ready three stages, input-ready two stages.
module dcffm_top
  import dcffm_pkg::*;
#(
  parameter int DATA_W = DCFFM_DATA_W,
  parameter int ADDR_W = DCFFM_ADDR_W,
  parameter int STAGE_DEPTH = DCFFM_STAGE_DEPTH
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic FALL_THROUGH_SELECT_SERIAL_INPUT_I,
  input wire logic WRITE_ENABLE_N_I,
  input wire logic [DATA_W-1:0] DATA_I,
  input wire logic READ_ENABLE_N_I,
  input wire logic [ADDR_W-1:0] EMPTY_OFFSET_I,
  input wire logic [ADDR_W-1:0] FULL_OFFSET_I,
  output logic [DATA_W-1:0] DATA_OUTPUTS_O,
  output logic EMPTY_FLAG_N_O,
  output logic FULL_FLAG_N_O,
  output logic OUTPUT_READY_N_O,
  output logic INPUT_READY_N_O,
  output logic ALMOST_EMPTY_FLAG_N_O,
  output logic ALMOST_FULL_FLAG_N_O,
  output logic HALF_FULL_FLAG_N_O,
  output logic FIRST_WORD_FALL_THROUGH_MODE_O
);

  // ==========================================================================
  // Widths and constants
  // Pointers carry one spare address bit so that the store can also hold
  // the extra word of fall-through mode before the output register loads.
  localparam int PW = ADDR_W + 1;
  localparam logic [PW:0] ZERO_C = '0;
  localparam logic [PW:0] ONE_C = (PW+1)'(1);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(2**ADDR_W);
  localparam logic [PW:0] HALF_C = DEPTH_C >> 1;

  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic wen_s1;
    logic wen_s2;
    logic ren_s1;
    logic ren_s2;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic [ADDR_W-1:0] offe_s1;
    logic [ADDR_W-1:0] offe_s2;
    logic [ADDR_W-1:0] offf_s1;
    logic [ADDR_W-1:0] offf_s2;
    logic [1:0] boot;
    logic ft_mode;
    logic [PW:0] acc_ptr;
    logic [PW:0] cmt_ptr;
    logic [PW:0] cmt_g1;
    logic [PW:0] cmt_g2;
    logic [PW:0] rd_ptr;
    logic [PW:0] cons_g1;
    logic [PW:0] cons_g2;
    logic out_valid;
    logic [DATA_W-1:0] dout;
    logic empty_s1;
    logic empty_s2;
    logic full_s1;
    logic full_s2;
    logic inrdy_s1;
    logic inrdy_s2;
    logic aempty_n;
    logic afull_n;
    logic half_n;
  } dcffm_state_t;

  localparam dcffm_state_t RST_C = '{
    sel_s1: 1'b0, sel_s2: 1'b0, wen_s1: 1'b1, wen_s2: 1'b1,
    ren_s1: 1'b1, ren_s2: 1'b1, din_s1: '0, din_s2: '0,
    offe_s1: '0, offe_s2: '0, offf_s1: '0, offf_s2: '0,
    boot: DCFFM_BOOT_RST, ft_mode: DCFFM_MODE_RST,
    acc_ptr: '0, cmt_ptr: '0, cmt_g1: '0, cmt_g2: '0,
    rd_ptr: '0, cons_g1: '0, cons_g2: '0, out_valid: 1'b0, dout: '0,
    empty_s1: DCFFM_EMPTY_RST, empty_s2: DCFFM_EMPTY_RST,
    full_s1: DCFFM_FULL_RST, full_s2: DCFFM_FULL_RST,
    inrdy_s1: DCFFM_INRDY_RST, inrdy_s2: DCFFM_INRDY_RST,
    aempty_n: DCFFM_AEMPTY_RST, afull_n: DCFFM_AFULL_RST,
    half_n: DCFFM_HALF_RST
  };

  dcffm_state_t q, d;
  logic [DATA_W-1:0] mem [2**PW];
  logic run;
  logic [PW:0] cons_sync;
  logic [PW:0] cmt_sync;
  logic [PW:0] wcount;
  logic [PW:0] mem_cnt;
  logic [PW:0] rcount;
  logic [PW:0] cap;
  logic mem_empty;
  logic full_raw;
  logic wr_req;
  logic drain;
  logic rd_fire;
  logic pop_out;
  logic fetch;

  dcffm_stream_if #(.W(DATA_W)) stg_in ();
  dcffm_stream_if #(.W(DATA_W)) stg_out ();

  // ==========================================================================
  // Gray helpers for the pointer exchange
  function automatic logic [PW:0] bin2gray(input logic [PW:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW:0] gray2bin(input logic [PW:0] g);
    logic [PW:0] b;
    b[PW] = g[PW];
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ==========================================================================
  // Staging buffer in the write path
  // Accepted words wait here one cycle before reaching the main store; its
  // ready gates write acceptance so nothing is dropped if it backs up.
  dcffm_stage_fifo #(
    .W(DATA_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .push(stg_in.snk),
    .pop(stg_out.src)
  );

  assign run = (q.boot == DCFFM_BOOT_DONE);
  assign stg_in.valid = wr_req;
  assign stg_in.data = q.din_s2;
  assign stg_out.ready = run;

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    // Pins go through two flops before any logic sees them
    d.sel_s1 = FALL_THROUGH_SELECT_SERIAL_INPUT_I;
    d.sel_s2 = q.sel_s1;
    d.wen_s1 = WRITE_ENABLE_N_I;
    d.wen_s2 = q.wen_s1;
    d.ren_s1 = READ_ENABLE_N_I;
    d.ren_s2 = q.ren_s1;
    d.din_s1 = DATA_I;
    d.din_s2 = q.din_s1;
    d.offe_s1 = EMPTY_OFFSET_I;
    d.offe_s2 = q.offe_s1;
    d.offf_s1 = FULL_OFFSET_I;
    d.offf_s2 = q.offf_s1;

    // Mode strap caught once the synchroniser holds the level seen at release
    if (!run) begin
      d.boot = q.boot + 2'h1;
    end
    if (q.boot == DCFFM_BOOT_CAPTURE) begin
      d.ft_mode = q.sel_s2;
    end

    // Counts from the far side's synchronised pointer
    cons_sync = gray2bin(q.cons_g2);
    cmt_sync = gray2bin(q.cmt_g2);
    wcount = q.acc_ptr - cons_sync;
    mem_cnt = cmt_sync - q.rd_ptr;
    mem_empty = (mem_cnt == ZERO_C);
    rcount = mem_cnt + (q.ft_mode ? (PW+1)'(q.out_valid) : ZERO_C);
    // Fall-through counts the output register as one more slot
    cap = q.ft_mode ? DEPTH_C + ONE_C : DEPTH_C;
    full_raw = (wcount >= cap);

    // Write side
    wr_req = run & ~q.wen_s2 & ~full_raw & stg_in.ready;
    if (wr_req) begin
      d.acc_ptr = q.acc_ptr + ONE_C;
    end
    drain = stg_out.valid & stg_out.ready;
    if (drain) begin
      d.cmt_ptr = q.cmt_ptr + ONE_C;
    end
    d.cmt_g1 = bin2gray(q.cmt_ptr);
    d.cmt_g2 = q.cmt_g1;

    // Read side; read pointer and data hold while the store is empty
    rd_fire = run & ~q.ft_mode & ~q.ren_s2 & ~mem_empty;
    pop_out = run & q.ft_mode & q.out_valid & ~q.ren_s2;
    fetch = run & q.ft_mode & ~mem_empty & (~q.out_valid | pop_out);
    if (rd_fire || fetch) begin
      d.rd_ptr = q.rd_ptr + ONE_C;
      d.dout = mem[q.rd_ptr[PW-1:0]];
    end
    d.out_valid = fetch | (q.out_valid & ~pop_out);
    // Words held in the output register are not yet consumed
    d.cons_g1 = bin2gray(q.rd_ptr - (PW+1)'(q.out_valid));
    d.cons_g2 = q.cons_g1;

    // Flags, frozen at reset values until the mode is known
    if (run && !q.ft_mode) begin
      d.empty_s1 = ~mem_empty;
      d.empty_s2 = q.empty_s1;
      d.full_s1 = ~full_raw;
      d.full_s2 = q.full_s1;
    end
    if (run && q.ft_mode) begin
      d.inrdy_s1 = full_raw;
      d.inrdy_s2 = q.inrdy_s1;
    end
    if (run) begin
      if (q.ft_mode) begin
        d.aempty_n = rcount > (PW+1)'(q.offe_s2) + ONE_C;
        d.half_n = ~(wcount >= HALF_C + ONE_C + ONE_C);
      end else begin
        d.aempty_n = rcount > (PW+1)'(q.offe_s2);
        d.half_n = ~(wcount > HALF_C);
      end
      d.afull_n = ~(wcount >= cap - (PW+1)'(q.offf_s2));
    end
  end

  // ==========================================================================
  // Registers
  // Main store has no reset; pointers alone say what is valid
  always_ff @(posedge CLK_I) begin
    if (drain) begin
      mem[q.cmt_ptr[PW-1:0]] <= stg_out.data;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= RST_C;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign DATA_OUTPUTS_O = q.dout;
  assign EMPTY_FLAG_N_O = q.empty_s2;
  assign FULL_FLAG_N_O = q.full_s2;
  assign OUTPUT_READY_N_O = ~q.out_valid;
  assign INPUT_READY_N_O = q.inrdy_s2;
  assign ALMOST_EMPTY_FLAG_N_O = q.aempty_n;
  assign ALMOST_FULL_FLAG_N_O = q.afull_n;
  assign HALF_FULL_FLAG_N_O = q.half_n;
  assign FIRST_WORD_FALL_THROUGH_MODE_O = q.ft_mode;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_held_three_then_valid;
    !q.out_valid [*3] ##1 q.out_valid;
  endsequence

  sequence s_first_commit;
    run && q.ft_mode && !q.out_valid && drain && (q.cmt_ptr == q.rd_ptr);
  endsequence

  property p_std_select;
    (q.boot == DCFFM_BOOT_CAPTURE && !q.sel_s2) |=> !q.ft_mode [*4];
  endproperty
  a_std_select: assert property (p_std_select)
    else $error("standard mode not taken from low select");

  property p_ft_select;
    (q.boot == DCFFM_BOOT_CAPTURE && q.sel_s2) |=> q.ft_mode [*4];
  endproperty
  a_ft_select: assert property (p_ft_select)
    else $error("fall-through mode not taken from high select");

  property p_first_fall;
    s_first_commit |=> s_held_three_then_valid;
  endproperty
  a_first_fall: assert property (p_first_fall)
    else $error("first word did not fall through on time");

  property p_write_needs_enable;
    (!run || q.wen_s2) |=> $stable(q.acc_ptr);
  endproperty
  a_write_needs_enable: assert property (p_write_needs_enable)
    else $error("word taken without write enable");

  property p_full_blocks;
    (run && full_raw) |=> $stable(q.acc_ptr);
  endproperty
  a_full_blocks: assert property (p_full_blocks)
    else $error("write accepted while full");

  property p_empty_ignores_read;
    (run && !q.ft_mode && mem_empty) |=> $stable(q.rd_ptr) && $stable(q.dout);
  endproperty
  a_empty_ignores_read: assert property (p_empty_ignores_read)
    else $error("read taken while empty");

  property p_std_two_stage;
    (run && !q.ft_mode && $past(run, 2)) |->
      (EMPTY_FLAG_N_O == $past(!mem_empty, 2)) &&
      (FULL_FLAG_N_O == $past(!full_raw, 2));
  endproperty
  a_std_two_stage: assert property (p_std_two_stage)
    else $error("standard flags not two stages behind");

  property p_ft_inrdy_stage;
    (run && q.ft_mode && $past(run, 2)) |->
      (INPUT_READY_N_O == $past(full_raw, 2));
  endproperty
  a_ft_inrdy_stage: assert property (p_ft_inrdy_stage)
    else $error("input ready not two stages behind");

  property p_full_means_almost_full;
    (run && full_raw) |=> !ALMOST_FULL_FLAG_N_O && !HALF_FULL_FLAG_N_O;
  endproperty
  a_full_means_almost_full: assert property (p_full_means_almost_full)
    else $error("almost-full or half-full high while full");

  property p_empty_means_almost_empty;
    (run && rcount == ZERO_C) |=> !ALMOST_EMPTY_FLAG_N_O;
  endproperty
  a_empty_means_almost_empty: assert property (p_empty_means_almost_empty)
    else $error("almost-empty high with no words");

  property p_gray_step;
    run |-> ($countones(q.cmt_g1 ^ $past(q.cmt_g1)) <= 1) &&
      ($countones(q.cons_g1 ^ $past(q.cons_g1)) <= 1);
  endproperty
  a_gray_step: assert property (p_gray_step)
    else $error("pointer crossing changed more than one bit");

endmodule

// file: dcffm_far_end.sv
// Writer and reader logic facing the FIFO, driven on rising edges
`timescale 1ns/10ps
module dcffm_far_end #(
  parameter int W = 16
) (
  input wire logic clk_i,
  output logic wr_en_n_o,
  output logic [W-1:0] wr_data_o,
  output logic rd_en_n_o
);
  // ==========================================================================
  // Idle levels
  initial begin
    wr_en_n_o = 1'b1;
    wr_data_o = '0;
    rd_en_n_o = 1'b1;
  end

  // Store one word; hold keeps enable low for a back-to-back burst
  task automatic put(input logic [W-1:0] w, input logic hold);
    wr_en_n_o <= 1'b0;
    wr_data_o <= w;
    @(posedge clk_i);
    if (!hold) begin
      wr_en_n_o <= 1'b1;
      wr_data_o <= ~w; // Released bus must not look like a valid word
    end
  endtask

  // Every word is asked for, the first one too
  task automatic pull();
    rd_en_n_o <= 1'b0;
    @(posedge clk_i);
    rd_en_n_o <= 1'b1;
  endtask
endmodule

// file: testbench.sv
// Self-checking bench for the two-mode flagged FIFO
`timescale 1ns/10ps
module testbench;
  import dcffm_pkg::*;
  localparam int W = 16;
  localparam int AW = 3;
  localparam int D = 8;
  logic clk, rst_n, fts, we_n, re_n;
  logic [W-1:0] din, dout, w;
  logic [AW-1:0] n_off, m_off;
  logic emp_n, ful_n, orn, irn, ae, af, half_n, mode;
  logic [7:0] st;
  int fail_count, check_count, cnt, k;
  integer seed;
  logic [W-1:0] q[$];

  assign st = {mode, emp_n, ful_n, orn, irn, ae, af, half_n};

  // ==========================================================================
  // Clock, design and far end
  initial begin
    clk = 1'b0;
    forever #(DCFFM_CLK_PERIOD_NS / 2) clk = ~clk;
  end

  dcffm_top #(.DATA_W(W), .ADDR_W(AW)) dcffm_top_i (
    .CLK_I(clk), .RST_N_I(rst_n), .FALL_THROUGH_SELECT_SERIAL_INPUT_I(fts),
    .WRITE_ENABLE_N_I(we_n), .DATA_I(din), .READ_ENABLE_N_I(re_n),
    .EMPTY_OFFSET_I(n_off), .FULL_OFFSET_I(m_off), .DATA_OUTPUTS_O(dout),
    .EMPTY_FLAG_N_O(emp_n), .FULL_FLAG_N_O(ful_n), .OUTPUT_READY_N_O(orn),
    .INPUT_READY_N_O(irn), .ALMOST_EMPTY_FLAG_N_O(ae),
    .ALMOST_FULL_FLAG_N_O(af), .HALF_FULL_FLAG_N_O(half_n),
    .FIRST_WORD_FALL_THROUGH_MODE_O(mode));

  dcffm_far_end #(.W(W)) dcffm_far_end_i (
    .clk_i(clk), .wr_en_n_o(we_n), .wr_data_o(din), .rd_en_n_o(re_n));

  // ==========================================================================
  // Expectations and comparisons
  // Flag vector for a word count; fall-through counts the output register
  function automatic logic [7:0] exp_st(input logic ft, input int c);
    int n = int'(n_off);
    int m = int'(m_off);
    if (ft) begin
      return {1'b1, 1'b0, 1'b1, c == 0, c >= D + 1, c > n + 1,
        !(c >= D + 1 - m), !(c >= D / 2 + 2)};
    end
    return {1'b0, c > 0, !(c >= D), 1'b1, 1'b0, c > n, !(c >= D - m),
      !(c > D / 2)};
  endfunction

  task automatic chk_flags(input logic [7:0] e);
    check_count++;
    if (st !== e) begin
      fail_count++;
      $display("wrong value at %0t: flags %b exp %b", $time, st, e);
    end
  endtask

  task automatic chk_data(input logic [W-1:0] e);
    check_count++;
    if (dout !== e) begin
      fail_count++;
      $display("wrong value at %0t: data %h exp %h", $time, dout, e);
    end
  endtask

  // Flags trail a write by about eight edges plus one stage
  task automatic settle();
    repeat (12) @(posedge clk);
  endtask

  task automatic do_reset(input logic ft);
    rst_n <= 1'b0;
    fts <= ft;
    repeat (3) @(posedge clk);
    chk_flags({DCFFM_MODE_RST, DCFFM_EMPTY_RST, DCFFM_FULL_RST, 1'b1,
      DCFFM_INRDY_RST, DCFFM_AEMPTY_RST, DCFFM_AFULL_RST, DCFFM_HALF_RST});
    chk_data('0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk); // Strap stays put past the capture edge
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end

  // ==========================================================================
  // Passes: even standard, odd fall-through; 2 and 3 burst with edge offsets
  initial begin
    seed = 32'hE6DC;
    fail_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    fts = 1'b0;
    n_off = '0;
    m_off = '0;
    for (int p = 0; p < 4; p++) begin
      n_off <= (p < 2) ? AW'($random(seed)) : ((p == 2) ? 3'h0 : 3'h7);
      m_off <= (p < 2) ? AW'($random(seed)) : ((p == 2) ? 3'h7 : 3'h0);
      do_reset(p[0]);
      cnt = 0;
      q.delete();
      chk_flags(exp_st(p[0], 0));
      // Fill past capacity; surplus words must be dropped
      for (int i = 0; i < D + 3; i++) begin
        w = W'($random(seed));
        dcffm_far_end_i.put(w, p >= 2 && i < D + 2);
        if (cnt < D + p[0]) begin
          q.push_back(w);
          cnt++;
        end
        if (p == 1 && i == 0) begin
          k = 0;
          while (orn !== 1'b0 && k < 20) begin
            @(posedge clk);
            k++;
          end
          if (k == 20) begin
            fail_count++;
            $display("wrong value at %0t: output ready never low", $time);
            conclude();
          end
          chk_data(q[0]);
        end
        if (p < 2 || i == D + 2) begin
          settle();
          chk_flags(exp_st(p[0], cnt));
        end
      end
      // Drain word by word, checking order and flags on the way down
      while (q.size() > 0) begin
        if (p[0]) chk_data(q[0]);
        dcffm_far_end_i.pull();
        settle();
        if (!p[0]) chk_data(q[0]);
        w = q.pop_front();
        cnt--;
        chk_flags(exp_st(p[0], cnt));
      end
      // Read while empty: no change
      dcffm_far_end_i.pull();
      settle();
      chk_flags(exp_st(p[0], 0));
      if (!p[0]) chk_data(w);
      $display("pass %0d fall_through %0b done", p, p[0]);
    end
    conclude();
  end
endmodule
